// file: hdl/cpu_addr_pkg.sv
// constants for the stack, wait-state and addressing-mode register bank
// assumes a 32-bit ahb-lite register bus, one register per aligned word
package cpu_addr_pkg;
  // ************************************************************
  // register indices; byte address is four times the index
  // ************************************************************
  localparam logic [7:0] IDX_STACK_LOW = 8'h81;
  localparam logic [7:0] IDX_WAIT = 8'h92;
  localparam logic [7:0] IDX_STACK_HIGH = 8'h9b;
  localparam logic [7:0] IDX_ADDR_MODE = 8'h9d;
  localparam logic [7:0] IDX_INT_STATUS = 8'hc5;
  localparam logic [7:0] IDX_XRAM_BASE = 8'hc6;
  localparam logic [7:0] IDX_TIMED_GUARD = 8'hc7;
  localparam logic [7:0] IDX_RI_PAGE = 8'hda;
  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] RST_STACK_LOW = 8'h00;
  localparam logic [7:0] RST_STACK_HIGH = 8'h00;
  localparam logic [3:0] RST_WAIT = 4'h7;
  localparam logic [7:0] RST_ADDR_MODE = 8'h00;
  localparam logic [7:0] RST_XRAM_BASE = 8'h00;
  localparam logic [7:0] RST_RI_PAGE = 8'h00;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int BIT_HIGH_PRIO = 6;
  localparam int BIT_LOW_PRIO = 5;
  localparam int BIT_VEC_SEL = 5;
  localparam int BIT_RI_PAGE_EN = 3;
  localparam int BIT_EXT_STACK = 2;
  localparam int BIT_AM1 = 1;
  localparam int BIT_AM0 = 0;
  localparam logic [7:0] ADDR_MODE_WMASK = 8'h2b;
  localparam logic [15:0] VEC_BASE_HIGH = 16'hb000;
  localparam logic [15:0] VEC_BASE_LOW = 16'h0000;
  // ************************************************************
  // timed-access unlock keys and window length in cycles
  // ************************************************************
  localparam logic [7:0] KEY_FIRST = 8'haa;
  localparam logic [7:0] KEY_SECOND = 8'h55;
  localparam logic [3:0] GUARD_WINDOW = 4'h8;
  // ************************************************************
  // state encodings
  // ************************************************************
  typedef enum logic {PM_IDLE = 1'b0, PM_WAIT = 1'b1} pm_state_t;
  typedef enum logic [1:0] {
    GUARD_LOCKED = 2'b00,
    GUARD_HALF = 2'b01,
    GUARD_OPEN = 2'b10
  } guard_state_t;
endpackage : cpu_addr_pkg

// file: hdl/cpu_addr_stack_wait.sv
// stack pointer, wait-state, xram base and addressing-mode register bank
// assumes an ahb-lite master, a sync stack ram with one-cycle read latency
`timescale 1ns/10ps
module cpu_addr_stack_wait (
  input wire logic clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic push_req,
  input wire logic pop_req,
  input wire logic [7:0] acc_in,
  input wire logic [7:0] stack_rdata,
  output logic stack_we,
  output logic stack_re,
  output logic [15:0] stack_addr,
  output logic [7:0] stack_wdata,
  output logic stack_ext,
  output logic acc_load,
  output logic [7:0] acc_out,
  input wire logic high_prio_active,
  input wire logic low_prio_active,
  input wire logic pm_req,
  output logic pm_busy,
  output logic pm_done,
  output logic wide_mode,
  output logic [15:0] vector_base,
  input wire logic [7:0] port_two_latch,
  output logic [7:0] ri_page_addr,
  output logic [7:0] xram_base
);
  // ************************************************************
  // bus slave
  // ************************************************************
  logic dp_valid_reg, dp_valid_next;
  logic dp_write_reg, dp_write_next;
  logic [7:0] dp_idx_reg, dp_idx_next;
  logic [31:0] rdata_reg, rdata_next;
  logic addr_take;
  logic [7:0] addr_idx;
  logic wr_en;
  logic [7:0] wr_byte;
  logic [7:0] ptr_low_reg, ptr_low_next;
  logic [7:0] ptr_high_reg, ptr_high_next;
  logic [3:0] wait_reg, wait_next;
  logic [7:0] mode_reg, mode_next;
  logic [7:0] xbase_reg, xbase_next;
  logic [7:0] page_reg, page_next;
  logic [7:0] status_val;
  cpu_addr_pkg::guard_state_t guard_reg, guard_next;
  logic [3:0] guard_cnt_reg, guard_cnt_next;

  // zero-wait slave, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;
  assign addr_take = hsel & htrans[1] & hready;
  assign addr_idx = haddr[9:2];
  assign wr_en = dp_valid_reg & dp_write_reg;
  assign wr_byte = hwdata[7:0];

  // status bits track live service levels; others read zero
  always_comb begin
    status_val = 8'h00;
    status_val[cpu_addr_pkg::BIT_HIGH_PRIO] = high_prio_active;
    status_val[cpu_addr_pkg::BIT_LOW_PRIO] = low_prio_active;
  end

  // address phase capture and read mux
  always_comb begin
    dp_valid_next = addr_take;
    dp_write_next = hwrite;
    dp_idx_next = addr_idx;
    rdata_next = 32'h0000_0000;
    if (addr_take && !hwrite && haddr[1:0] == 2'b00) begin
      case (addr_idx)
        cpu_addr_pkg::IDX_STACK_LOW: rdata_next[7:0] = ptr_low_next;
        cpu_addr_pkg::IDX_STACK_HIGH: rdata_next[7:0] = ptr_high_next;
        cpu_addr_pkg::IDX_WAIT: rdata_next[3:0] = wait_reg;
        cpu_addr_pkg::IDX_ADDR_MODE: rdata_next[7:0] = mode_reg;
        cpu_addr_pkg::IDX_INT_STATUS: rdata_next[7:0] = status_val;
        cpu_addr_pkg::IDX_XRAM_BASE: rdata_next[7:0] = xbase_reg;
        cpu_addr_pkg::IDX_TIMED_GUARD: rdata_next[0] = (guard_reg == cpu_addr_pkg::GUARD_OPEN);
        cpu_addr_pkg::IDX_RI_PAGE: rdata_next[7:0] = page_reg;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_idx_reg <= 8'h00;
      rdata_reg <= 32'h0000_0000;
    end else begin
      dp_valid_reg <= dp_valid_next;
      dp_write_reg <= dp_write_next;
      dp_idx_reg <= dp_idx_next;
      rdata_reg <= rdata_next;
    end
  end

  // ************************************************************
  // timed-access guard
  // ************************************************************
  logic guard_wr, prot_wr;
  assign guard_wr = wr_en && dp_idx_reg == cpu_addr_pkg::IDX_TIMED_GUARD;
  assign prot_wr = wr_en && (dp_idx_reg == cpu_addr_pkg::IDX_ADDR_MODE ||
                             dp_idx_reg == cpu_addr_pkg::IDX_XRAM_BASE);

  // unlock pair opens a short window; one protected write closes it
  always_comb begin
    guard_next = guard_reg;
    guard_cnt_next = guard_cnt_reg;
    case (guard_reg)
      cpu_addr_pkg::GUARD_LOCKED: begin
        if (guard_wr && wr_byte == cpu_addr_pkg::KEY_FIRST) begin
          guard_next = cpu_addr_pkg::GUARD_HALF;
        end
      end
      cpu_addr_pkg::GUARD_HALF: begin
        if (guard_wr && wr_byte == cpu_addr_pkg::KEY_SECOND) begin
          guard_next = cpu_addr_pkg::GUARD_OPEN;
          guard_cnt_next = cpu_addr_pkg::GUARD_WINDOW;
        end else if (wr_en) begin
          guard_next = cpu_addr_pkg::GUARD_LOCKED;
        end
      end
      cpu_addr_pkg::GUARD_OPEN: begin
        guard_cnt_next = guard_cnt_reg - 4'h1;
        if (prot_wr || guard_cnt_reg == 4'h1) begin
          guard_next = cpu_addr_pkg::GUARD_LOCKED;
          guard_cnt_next = 4'h0;
        end
      end
      default: begin
        guard_next = cpu_addr_pkg::GUARD_LOCKED;
        guard_cnt_next = 4'h0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      guard_reg <= cpu_addr_pkg::GUARD_LOCKED;
      guard_cnt_reg <= 4'h0;
    end else begin
      guard_reg <= guard_next;
      guard_cnt_reg <= guard_cnt_next;
    end
  end

  // ************************************************************
  // configuration registers
  // ************************************************************
  logic unlocked;
  assign unlocked = (guard_reg == cpu_addr_pkg::GUARD_OPEN);

  // plain and guarded register writes
  always_comb begin
    wait_next = wait_reg;
    mode_next = mode_reg;
    xbase_next = xbase_reg;
    page_next = page_reg;
    if (wr_en && dp_idx_reg == cpu_addr_pkg::IDX_WAIT) begin
      wait_next = wr_byte[3:0];
    end
    if (wr_en && unlocked && dp_idx_reg == cpu_addr_pkg::IDX_ADDR_MODE) begin
      mode_next = wr_byte & cpu_addr_pkg::ADDR_MODE_WMASK;
    end
    if (wr_en && unlocked && dp_idx_reg == cpu_addr_pkg::IDX_XRAM_BASE) begin
      xbase_next = wr_byte;
    end
    if (wr_en && dp_idx_reg == cpu_addr_pkg::IDX_RI_PAGE) begin
      page_next = wr_byte;
    end
    // extended stack indicator follows the wide mode bit
    mode_next[cpu_addr_pkg::BIT_EXT_STACK] = mode_next[cpu_addr_pkg::BIT_AM1];
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_reg <= cpu_addr_pkg::RST_WAIT;
      mode_reg <= cpu_addr_pkg::RST_ADDR_MODE;
      xbase_reg <= cpu_addr_pkg::RST_XRAM_BASE;
      page_reg <= cpu_addr_pkg::RST_RI_PAGE;
    end else begin
      wait_reg <= wait_next;
      mode_reg <= mode_next;
      xbase_reg <= xbase_next;
      page_reg <= page_next;
    end
  end

  // mode decode drives the core address paths
  assign wide_mode = mode_reg[cpu_addr_pkg::BIT_AM1];
  assign stack_ext = mode_reg[cpu_addr_pkg::BIT_EXT_STACK];
  assign vector_base = mode_reg[cpu_addr_pkg::BIT_VEC_SEL] ?
                       cpu_addr_pkg::VEC_BASE_HIGH : cpu_addr_pkg::VEC_BASE_LOW;
  assign ri_page_addr = mode_reg[cpu_addr_pkg::BIT_RI_PAGE_EN] ?
                        page_reg : port_two_latch;
  assign xram_base = xbase_reg;

  // ************************************************************
  // stack pointer and push / pop
  // ************************************************************
  logic [15:0] ptr_full, ptr_inc, ptr_dec;
  logic we_reg, we_next;
  logic re_reg, re_next;
  logic rd_pend_reg, rd_pend_next;
  logic load_reg, load_next;
  logic [15:0] saddr_reg, saddr_next;
  logic [7:0] swdata_reg, swdata_next;
  logic [7:0] acc_reg, acc_next;

  // wide mode carries into the high byte, legacy wraps in 256 bytes
  assign ptr_full = {ptr_high_reg, ptr_low_reg};
  assign ptr_inc = wide_mode ? ptr_full + 16'h0001 : {8'h00, ptr_low_reg + 8'h01};
  assign ptr_dec = wide_mode ? ptr_full - 16'h0001 : {8'h00, ptr_low_reg - 8'h01};

  // push has priority over pop; a bus write overrides the pointer byte it addresses
  always_comb begin
    ptr_low_next = ptr_low_reg;
    ptr_high_next = ptr_high_reg;
    we_next = 1'b0;
    re_next = 1'b0;
    saddr_next = saddr_reg;
    swdata_next = swdata_reg;
    rd_pend_next = re_reg;
    load_next = rd_pend_reg;
    acc_next = rd_pend_reg ? stack_rdata : acc_reg;
    if (push_req) begin
      we_next = 1'b1;
      saddr_next = ptr_inc;
      swdata_next = acc_in;
      ptr_low_next = ptr_inc[7:0];
      if (wide_mode) begin
        ptr_high_next = ptr_inc[15:8];
      end
    end else if (pop_req) begin
      re_next = 1'b1;
      saddr_next = wide_mode ? ptr_full : {8'h00, ptr_low_reg};
      ptr_low_next = ptr_dec[7:0];
      if (wide_mode) begin
        ptr_high_next = ptr_dec[15:8];
      end
    end
    if (wr_en && dp_idx_reg == cpu_addr_pkg::IDX_STACK_LOW) begin
      ptr_low_next = wr_byte;
    end
    if (wr_en && dp_idx_reg == cpu_addr_pkg::IDX_STACK_HIGH) begin
      ptr_high_next = wr_byte;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ptr_low_reg <= cpu_addr_pkg::RST_STACK_LOW;
      ptr_high_reg <= cpu_addr_pkg::RST_STACK_HIGH;
      we_reg <= 1'b0;
      re_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      load_reg <= 1'b0;
      saddr_reg <= 16'h0000;
      swdata_reg <= 8'h00;
      acc_reg <= 8'h00;
    end else begin
      ptr_low_reg <= ptr_low_next;
      ptr_high_reg <= ptr_high_next;
      we_reg <= we_next;
      re_reg <= re_next;
      rd_pend_reg <= rd_pend_next;
      load_reg <= load_next;
      saddr_reg <= saddr_next;
      swdata_reg <= swdata_next;
      acc_reg <= acc_next;
    end
  end

  assign stack_we = we_reg;
  assign stack_re = re_reg;
  assign stack_addr = saddr_reg;
  assign stack_wdata = swdata_reg;
  assign acc_load = load_reg;
  assign acc_out = acc_reg;

  // ************************************************************
  // program-memory wait states
  // ************************************************************
  cpu_addr_pkg::pm_state_t pm_reg, pm_next;
  logic [3:0] pm_cnt_reg, pm_cnt_next;

  // access occupies wait field plus one cycles
  always_comb begin
    pm_next = pm_reg;
    pm_cnt_next = pm_cnt_reg;
    case (pm_reg)
      cpu_addr_pkg::PM_IDLE: begin
        if (pm_req) begin
          pm_next = cpu_addr_pkg::PM_WAIT;
          pm_cnt_next = wait_reg;
        end
      end
      cpu_addr_pkg::PM_WAIT: begin
        if (pm_cnt_reg == 4'h0) begin
          pm_next = cpu_addr_pkg::PM_IDLE;
        end else begin
          pm_cnt_next = pm_cnt_reg - 4'h1;
        end
      end
      default: pm_next = cpu_addr_pkg::PM_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pm_reg <= cpu_addr_pkg::PM_IDLE;
      pm_cnt_reg <= 4'h0;
    end else begin
      pm_reg <= pm_next;
      pm_cnt_reg <= pm_cnt_next;
    end
  end

  assign pm_busy = (pm_reg == cpu_addr_pkg::PM_WAIT);
  assign pm_done = pm_busy && pm_cnt_reg == 4'h0;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_push_target: assert property (push_req ##1 1'b1 |->
    stack_we && stack_wdata == $past(acc_in) && stack_addr[7:0] == $past(ptr_low_reg) + 8'h01
    ) else $error("push address or data wrong");
  a_pop_load: assert property (pop_req && !push_req |=>
    stack_re ##2 acc_load) else $error("pop did not load accumulator");
  a_wide_stack: assert property (push_req && wide_mode |=>
    stack_addr == $past(ptr_full) + 16'h0001) else $error("wide stack address wrong");
  a_high_status: assert property (addr_take && !hwrite &&
    addr_idx == cpu_addr_pkg::IDX_INT_STATUS && haddr[1:0] == 2'b00 |=>
    hrdata[6] == $past(high_prio_active) && hrdata[5] == $past(low_prio_active)
    ) else $error("status flags wrong");
  a_status_rsvd: assert property (addr_take && !hwrite &&
    addr_idx == cpu_addr_pkg::IDX_INT_STATUS |=>
    hrdata[31:7] == 25'h0 && hrdata[4:0] == 5'h0) else $error("status reserved set");
  a_wait_len: assert property (pm_req && !pm_busy && wait_reg == 4'h3 |=>
    !pm_done [*3] ##1 pm_done) else $error("wait stretch wrong");
  a_mode_guard: assert property (wr_en && dp_idx_reg == cpu_addr_pkg::IDX_ADDR_MODE &&
    !unlocked |=> $stable(mode_reg)) else $error("guarded write got through");
  a_base_guard: assert property (wr_en && dp_idx_reg == cpu_addr_pkg::IDX_XRAM_BASE &&
    !unlocked |=> $stable(xbase_reg)) else $error("xram base changed locked");
  a_ext_flag: assert property (wr_en && unlocked &&
    dp_idx_reg == cpu_addr_pkg::IDX_ADDR_MODE |=>
    stack_ext == $past(wr_byte[cpu_addr_pkg::BIT_AM1])) else $error("stack flag not read-only");
  a_guard_window: assert property ($rose(unlocked) |-> ##[1:8] !unlocked
    ) else $error("guard window too long");
  a_page_src: assert property (!mode_reg[cpu_addr_pkg::BIT_RI_PAGE_EN] |->
    ri_page_addr == port_two_latch) else $error("page source wrong");
endmodule : cpu_addr_stack_wait

// file: tb/cpu_addressing_stack_wait_ctrl_test.sv
// self-checking bench for the stack, wait-state and addressing-mode bank
// assumes ahb-lite slave with hreadyout fed back as hready, one clock
`timescale 1ns/10ps
module cpu_addressing_stack_wait_ctrl_test;
  // ************************************************************
  // signals and model state
  // ************************************************************
  logic clk, resetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic push_req, pop_req, stack_we, stack_re, stack_ext, acc_load;
  logic [7:0] acc_in, stack_rdata, stack_wdata, acc_out, port_two_latch, ri_page_addr, xram_base;
  logic [15:0] stack_addr, vector_base;
  logic high_prio_active, low_prio_active, pm_req, pm_busy, pm_done, wide_mode;
  int mdl [256];
  int ptr_lo, ptr_hi, wide, bad_count, checks, cycles;
  logic [31:0] xs_state, rdv;
  logic [7:0] regs [7];
  // bus slave always ready, so hready simply follows the slave
  assign hready = hreadyout;
  cpu_addr_stack_wait u_cpu_addr_stack_wait (.clk(clk), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .push_req(push_req), .pop_req(pop_req), .acc_in(acc_in), .stack_rdata(stack_rdata),
    .stack_we(stack_we), .stack_re(stack_re), .stack_addr(stack_addr),
    .stack_wdata(stack_wdata), .stack_ext(stack_ext), .acc_load(acc_load), .acc_out(acc_out),
    .high_prio_active(high_prio_active), .low_prio_active(low_prio_active), .pm_req(pm_req),
    .pm_busy(pm_busy), .pm_done(pm_done), .wide_mode(wide_mode), .vector_base(vector_base),
    .port_two_latch(port_two_latch), .ri_page_addr(ri_page_addr), .xram_base(xram_base));
  // ************************************************************
  // clock, timeout and helpers
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      summarize();
    end
  end
  function automatic logic [31:0] xs();
    xs_state ^= xs_state << 13;
    xs_state ^= xs_state >> 17;
    xs_state ^= xs_state << 5;
    return xs_state;
  endfunction : xs
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  // ************************************************************
  // ahb-lite single word transfer, waits on hready at each phase
  // ************************************************************
  task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= {24'h0, wd};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rdv = hrdata;
    check("hresp", hresp, 0);
  endtask : bus
  task automatic rdc(input logic [7:0] idx);
    bus(idx, 1'b0, 8'h00);
    check($sformatf("reg %h", idx), rdv, mdl[idx]);
  endtask : rdc
  task automatic unlock();
    bus(8'hc7, 1'b1, 8'haa);
    bus(8'hc7, 1'b1, 8'h55);
  endtask : unlock
  // ************************************************************
  // stack operations against the pointer model
  // ************************************************************
  task automatic push_chk(input logic [7:0] a);
    int v;
    @(posedge clk);
    push_req <= 1'b1;
    acc_in <= a;
    @(posedge clk);
    push_req <= 1'b0;
    acc_in <= ~a;
    #1;
    v = wide ? ((ptr_hi * 256 + ptr_lo + 1) & 65535) : ((ptr_lo + 1) & 255) + ptr_hi * 256;
    ptr_lo = v & 255;
    ptr_hi = v >> 8;
    check("stack_we", stack_we, 1);
    check("push addr", stack_addr, wide ? v : ptr_lo);
    check("stack_wdata", stack_wdata, a);
    mdl[8'h81] = ptr_lo;
    mdl[8'h9b] = ptr_hi;
  endtask : push_chk
  task automatic pop_chk(input logic [7:0] d);
    int v;
    @(posedge clk);
    pop_req <= 1'b1;
    @(posedge clk);
    pop_req <= 1'b0;
    #1;
    v = ptr_hi * 256 + ptr_lo;
    check("stack_re", stack_re, 1);
    check("pop addr", stack_addr, wide ? v : ptr_lo);
    v = wide ? ((v + 65535) & 65535) : ((ptr_lo + 255) & 255) + ptr_hi * 256;
    ptr_lo = v & 255;
    ptr_hi = v >> 8;
    mdl[8'h81] = ptr_lo;
    mdl[8'h9b] = ptr_hi;
    @(posedge clk);
    stack_rdata <= d;
    @(posedge clk);
    stack_rdata <= ~d;
    #1;
    check("acc_load", acc_load, 1);
    check("acc_out", acc_out, d);
  endtask : pop_chk
  // program access lasts wait field plus one cycles
  task automatic pm_chk(input int w);
    bus(8'h92, 1'b1, w[7:0]);
    mdl[8'h92] = w;
    rdc(8'h92);
    @(posedge clk);
    pm_req <= 1'b1;
    @(posedge clk);
    pm_req <= 1'b0;
    #1;
    for (int i = 0; i <= w; i++) begin
      check("pm_busy", pm_busy, 1);
      check("pm_done", pm_done, i == w);
      @(posedge clk);
      #1;
    end
    check("pm_busy end", pm_busy, 0);
  endtask : pm_chk
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    {resetn, hsel, hwrite, push_req, pop_req, pm_req} = '0;
    {high_prio_active, low_prio_active, wide, ptr_lo, ptr_hi, bad_count, checks, cycles} = '0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'b00;
    hsize = 3'b010;
    xs_state = 32'h70e2e53f;
    acc_in = 8'h00;
    stack_rdata = 8'h00;
    port_two_latch = 8'(xs());
    foreach (mdl[i]) mdl[i] = 0;
    mdl[8'h92] = 7;
    regs = '{8'h81, 8'h92, 8'h9b, 8'h9d, 8'hc5, 8'hc6, 8'h40};
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    foreach (regs[i]) rdc(regs[i]);
    check("vector_base", vector_base, 16'h0000);
    check("ri_page_addr", ri_page_addr, port_two_latch);
    check("wide_mode", wide_mode, 0);
    // status flags follow the priority inputs, writes ignored
    bus(8'hc5, 1'b1, 8'hff);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      high_prio_active <= k[1];
      low_prio_active <= k[0];
      mdl[8'hc5] = k * 32;
      rdc(8'hc5);
    end
    // legacy stack wraps inside the low byte
    ptr_lo = 255;
    ptr_hi = xs() & 255;
    bus(8'h81, 1'b1, ptr_lo[7:0]);
    bus(8'h9b, 1'b1, ptr_hi[7:0]);
    push_chk(8'(xs()));
    rdc(8'h81);
    rdc(8'h9b);
    pop_chk(8'(xs()));
    rdc(8'h81);
    // guarded mode register: dropped when locked, taken when open
    mdl[8'hda] = xs() & 255;
    bus(8'hda, 1'b1, 8'(mdl[8'hda]));
    bus(8'h9d, 1'b1, 8'hff);
    rdc(8'h9d);
    unlock();
    bus(8'h9d, 1'b1, 8'hff);
    mdl[8'h9d] = 8'h2f;
    rdc(8'h9d);
    check("wide_mode", wide_mode, 1);
    check("stack_ext", stack_ext, 1);
    check("vector_base", vector_base, 16'hb000);
    check("ri_page_addr", ri_page_addr, mdl[8'hda]);
    // wide stack carries and borrows across the two bytes
    wide = 1;
    ptr_lo = 255;
    ptr_hi = 8'h12;
    bus(8'h81, 1'b1, 8'hff);
    bus(8'h9b, 1'b1, 8'h12);
    push_chk(8'(xs()));
    rdc(8'h9b);
    pop_chk(8'(xs()));
    rdc(8'h81);
    rdc(8'h9b);
    // xram base: window expiry drops the write, open window takes it
    unlock();
    repeat (12) @(posedge clk);
    bus(8'hc6, 1'b1, 8'h05);
    rdc(8'hc6);
    unlock();
    mdl[8'hc6] = xs() & 255;
    bus(8'hc6, 1'b1, 8'(mdl[8'hc6]));
    rdc(8'hc6);
    check("xram_base", xram_base, mdl[8'hc6]);
    unlock();
    // bit 2 is read-only: it must follow bit 1, not this write
    bus(8'h9d, 1'b1, 8'h04);
    mdl[8'h9d] = 0;
    rdc(8'h9d);
    @(posedge clk);
    port_two_latch <= 8'(xs());
    @(posedge clk);
    #1;
    check("vector_base", vector_base, 16'h0000);
    check("ri_page_addr", ri_page_addr, port_two_latch);
    check("stack_ext", stack_ext, 0);
    foreach (regs[i]) if (i < 4) pm_chk(i == 3 ? 15 : i * 3);
    // leave a wait setting above one for the fast system clock
    pm_chk(7);
    summarize();
  end
endmodule : cpu_addressing_stack_wait_ctrl_test
